/* File: src/iplr_pkg.sv */
package iplr_pkg;

    // ------------------------------------------------------------------
    // bus and register geometry
    // ------------------------------------------------------------------
    localparam int          ADDR_W   = 4;
    localparam int          DATA_W   = 16;
    localparam int          FIELD_W  = 2;
    localparam int          SLOTS    = DATA_W / FIELD_W;
    localparam int          LEVEL_W  = 2;

    localparam logic [ADDR_W-1:0] OFS_BANK_FOUR = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_BANK_FIVE = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_BANK_SIX  = 4'h6;

    localparam logic [DATA_W-1:0] BANK_RESET  = 16'h0000;
    localparam logic [DATA_W-1:0] RDATA_IDLE  = 16'h0000;
    // writable bits; everything else is reserved and reads zero
    localparam logic [DATA_W-1:0] MASK_FOUR   = 16'hfc3f;
    localparam logic [DATA_W-1:0] MASK_FIVE   = 16'hff3f;
    localparam logic [DATA_W-1:0] MASK_SIX    = 16'hffcf;

    // ------------------------------------------------------------------
    // field codes and decoded levels
    // ------------------------------------------------------------------
    localparam logic [FIELD_W-1:0] CODE_OFF = 2'h0;
    localparam logic [FIELD_W-1:0] CODE_L0  = 2'h1;
    localparam logic [FIELD_W-1:0] CODE_L1  = 2'h2;
    localparam logic [FIELD_W-1:0] CODE_L2  = 2'h3;
    localparam logic [LEVEL_W-1:0] LEVEL_0  = 2'h0;
    localparam logic [LEVEL_W-1:0] LEVEL_1  = 2'h1;
    localparam logic [LEVEL_W-1:0] LEVEL_2  = 2'h2;

    // ------------------------------------------------------------------
    // field slots: slot n covers bits 2n+1..2n
    // ------------------------------------------------------------------
    localparam int SLOT_SPI0_RX_FULL   = 7;
    localparam int SLOT_SPI1_TX_EMPTY  = 6;
    localparam int SLOT_SPI1_RX_FULL   = 5;
    localparam int SLOT_PORT_A         = 2;
    localparam int SLOT_PORT_B         = 1;
    localparam int SLOT_PORT_C         = 0;

    localparam int SLOT_DEC1_INDEX     = 7;
    localparam int SLOT_DEC1_HOME_WDOG = 6;
    localparam int SLOT_SER1_RX_FULL   = 5;
    localparam int SLOT_SER1_RX_ERROR  = 4;
    localparam int SLOT_SER1_TX_IDLE   = 2;
    localparam int SLOT_SER1_TX_EMPTY  = 1;
    localparam int SLOT_SPI0_TX_EMPTY  = 0;

    localparam int SLOT_TMR_C_CH0      = 7;
    localparam int SLOT_TMR_D_CH3      = 6;
    localparam int SLOT_TMR_D_CH2      = 5;
    localparam int SLOT_TMR_D_CH1      = 4;
    localparam int SLOT_TMR_D_CH0      = 3;
    localparam int SLOT_DEC0_INDEX     = 1;
    localparam int SLOT_DEC0_HOME_WDOG = 0;

    // ------------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------------
    function automatic logic field_enable(input logic [FIELD_W-1:0] code);
        return (code != CODE_OFF);
    endfunction

    function automatic logic [LEVEL_W-1:0] field_level(input logic [FIELD_W-1:0] code);
        logic [LEVEL_W-1:0] lvl;
        unique case (code)
            CODE_L1: lvl = LEVEL_1;
            CODE_L2: lvl = LEVEL_2;
            // disabled reports level 0 with enable low
            default: lvl = LEVEL_0;
        endcase
        return lvl;
    endfunction

endpackage

/* File: src/iplr_bank_reg.sv */
`timescale 1ns/1ps
`default_nettype none
module iplr_bank_reg (
    input  wire logic                         i_clk,
    input  wire logic                         i_rst,
    input  wire logic                         i_wr,
    input  wire logic [iplr_pkg::DATA_W-1:0] i_wdata,
    input  wire logic [iplr_pkg::DATA_W-1:0] i_mask,
    output logic      [iplr_pkg::DATA_W-1:0] o_value
);
    import iplr_pkg::*;

    // reserved bits are never stored, so they read zero everywhere
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_value <= BANK_RESET;
        end else if (i_wr) begin
            o_value <= i_wdata & i_mask;
        end
    end
endmodule
`default_nettype wire

/* File: src/iplr_bank_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module iplr_bank_decode (
    input  wire logic                                 i_clk,
    input  wire logic                                 i_rst,
    input  wire logic [iplr_pkg::DATA_W-1:0]          i_bank,
    output logic      [iplr_pkg::SLOTS-1:0]           o_en,
    output logic      [iplr_pkg::SLOTS*iplr_pkg::LEVEL_W-1:0] o_level
);
    import iplr_pkg::*;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_en    <= '0;
            o_level <= '0;
        end else begin
            for (int k = 0; k < SLOTS; k++) begin
                o_en[k]                   <= field_enable(i_bank[k*FIELD_W +: FIELD_W]);
                o_level[k*LEVEL_W +: LEVEL_W] <= field_level(i_bank[k*FIELD_W +: FIELD_W]);
            end
        end
    end
endmodule
`default_nettype wire

/* File: src/iplr_top.sv */
// Overview of operation
// - field code 00 disables, 01 level 0, 10 level 1, 11 level 2
// - sources take only levels 0 to 2; every field resets to 00
// - reserved bits read zero and ignore writes
// - bank four: 13-12 spi1 transmit empty, 11-10 spi1 receive full
// - bank four: 9-6 reserved; 5-4, 3-2, 1-0 ports a, b, c
// - bank five: 15-14 decoder1 index, 13-12 decoder1 home or watchdog
// - bank five: 11-10 serial1 rx full, 9-8 rx error, 7-6 reserved
// - bank five: 5-4 serial1 tx idle, 3-2 tx empty, 1-0 spi0 tx empty
// - bank six: 15-14 timer c0, 13-6 timer d3..d0, 5-4 reserved
// - bank six: 3-2 decoder0 index, 1-0 decoder0 home or watchdog
// - each bank is sixteen bits, all cleared by reset
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module iplr_top (
    input  wire logic                          i_clk,
    input  wire logic                          i_rst,
    input  wire logic [iplr_pkg::ADDR_W-1:0]  i_addr,
    input  wire logic [iplr_pkg::DATA_W-1:0]  i_wdata,
    input  wire logic                          i_wr,
    input  wire logic                          i_rd,
    output logic      [iplr_pkg::DATA_W-1:0]  o_rdata,
    output logic                               o_spi_ch0_rx_full_en,
    output logic      [iplr_pkg::LEVEL_W-1:0] o_spi_ch0_rx_full_level,
    output logic                               o_spi_ch1_tx_empty_en,
    output logic      [iplr_pkg::LEVEL_W-1:0] o_spi_ch1_tx_empty_level,
    output logic                               o_spi_ch1_rx_full_en,
    output logic      [iplr_pkg::LEVEL_W-1:0] o_spi_ch1_rx_full_level,
    output logic                               o_pin_port_a_en,
    output logic      [iplr_pkg::LEVEL_W-1:0] o_pin_port_a_level,
    output logic                               o_pin_port_b_en,
    output logic      [iplr_pkg::LEVEL_W-1:0] o_pin_port_b_level,
    output logic                               o_pin_port_c_en,
    output logic      [iplr_pkg::LEVEL_W-1:0] o_pin_port_c_level,
    output logic                               o_decoder1_index_en,
    output logic      [iplr_pkg::LEVEL_W-1:0] o_decoder1_index_level,
    output logic                               o_decoder1_home_wdog_en,
    output logic      [iplr_pkg::LEVEL_W-1:0] o_decoder1_home_wdog_level,
    output logic                               o_serial1_rx_full_en,
    output logic      [iplr_pkg::LEVEL_W-1:0] o_serial1_rx_full_level,
    output logic                               o_serial1_rx_error_en,
    output logic      [iplr_pkg::LEVEL_W-1:0] o_serial1_rx_error_level,
    output logic                               o_serial1_tx_idle_en,
    output logic      [iplr_pkg::LEVEL_W-1:0] o_serial1_tx_idle_level,
    output logic                               o_serial1_tx_empty_en,
    output logic      [iplr_pkg::LEVEL_W-1:0] o_serial1_tx_empty_level,
    output logic                               o_spi_ch0_tx_empty_en,
    output logic      [iplr_pkg::LEVEL_W-1:0] o_spi_ch0_tx_empty_level,
    output logic                               o_timer_c_ch0_en,
    output logic      [iplr_pkg::LEVEL_W-1:0] o_timer_c_ch0_level,
    output logic                               o_timer_d_ch3_en,
    output logic      [iplr_pkg::LEVEL_W-1:0] o_timer_d_ch3_level,
    output logic                               o_timer_d_ch2_en,
    output logic      [iplr_pkg::LEVEL_W-1:0] o_timer_d_ch2_level,
    output logic                               o_timer_d_ch1_en,
    output logic      [iplr_pkg::LEVEL_W-1:0] o_timer_d_ch1_level,
    output logic                               o_timer_d_ch0_en,
    output logic      [iplr_pkg::LEVEL_W-1:0] o_timer_d_ch0_level,
    output logic                               o_decoder0_index_en,
    output logic      [iplr_pkg::LEVEL_W-1:0] o_decoder0_index_level,
    output logic                               o_decoder0_home_wdog_en,
    output logic      [iplr_pkg::LEVEL_W-1:0] o_decoder0_home_wdog_level
);
    import iplr_pkg::*;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    logic                       wr_four;
    logic                       wr_five;
    logic                       wr_six;
    logic [DATA_W-1:0]          priority_bank_four;
    logic [DATA_W-1:0]          priority_bank_five;
    logic [DATA_W-1:0]          priority_bank_six;
    logic [SLOTS-1:0]           four_en;
    logic [SLOTS-1:0]           five_en;
    logic [SLOTS-1:0]           six_en;
    logic [SLOTS*LEVEL_W-1:0]   four_lvl;
    logic [SLOTS*LEVEL_W-1:0]   five_lvl;
    logic [SLOTS*LEVEL_W-1:0]   six_lvl;

    // unmapped writes fall through and change nothing
    assign wr_four = i_wr && (i_addr == OFS_BANK_FOUR);
    assign wr_five = i_wr && (i_addr == OFS_BANK_FIVE);
    assign wr_six  = i_wr && (i_addr == OFS_BANK_SIX);

    // ------------------------------------------------------------------
    // priority banks
    // ------------------------------------------------------------------
    // banks cleared at reset
    iplr_bank_reg u_bank_four (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_wr    (wr_four),
        .i_wdata (i_wdata),
        .i_mask  (MASK_FOUR),
        .o_value (priority_bank_four)
    );

    iplr_bank_reg u_bank_five (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_wr    (wr_five),
        .i_wdata (i_wdata),
        .i_mask  (MASK_FIVE),
        .o_value (priority_bank_five)
    );

    iplr_bank_reg u_bank_six (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_wr    (wr_six),
        .i_wdata (i_wdata),
        .i_mask  (MASK_SIX),
        .o_value (priority_bank_six)
    );

    // ------------------------------------------------------------------
    // field decode toward arbitration
    // ------------------------------------------------------------------
    // code to level
    iplr_bank_decode u_dec_four (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_bank  (priority_bank_four),
        .o_en    (four_en),
        .o_level (four_lvl)
    );

    iplr_bank_decode u_dec_five (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_bank  (priority_bank_five),
        .o_en    (five_en),
        .o_level (five_lvl)
    );

    iplr_bank_decode u_dec_six (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_bank  (priority_bank_six),
        .o_en    (six_en),
        .o_level (six_lvl)
    );

    // ------------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------------
    // read data stand for exactly one cycle, zero otherwise
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rdata <= RDATA_IDLE;
        end else if (i_rd) begin
            unique case (i_addr)
                OFS_BANK_FOUR: o_rdata <= priority_bank_four;
                OFS_BANK_FIVE: o_rdata <= priority_bank_five;
                OFS_BANK_SIX:  o_rdata <= priority_bank_six;
                default:       o_rdata <= RDATA_IDLE;
            endcase
        end else begin
            o_rdata <= RDATA_IDLE;
        end
    end

    // ------------------------------------------------------------------
    // per-source outputs, all from decoder flops
    // ------------------------------------------------------------------
    // bank four slots: spi0 rx full, spi1, ports a to c
    assign o_spi_ch0_rx_full_en       = four_en[SLOT_SPI0_RX_FULL];
    assign o_spi_ch0_rx_full_level    = four_lvl[SLOT_SPI0_RX_FULL*LEVEL_W +: LEVEL_W];
    assign o_spi_ch1_tx_empty_en      = four_en[SLOT_SPI1_TX_EMPTY];
    assign o_spi_ch1_tx_empty_level   = four_lvl[SLOT_SPI1_TX_EMPTY*LEVEL_W +: LEVEL_W];
    assign o_spi_ch1_rx_full_en       = four_en[SLOT_SPI1_RX_FULL];
    assign o_spi_ch1_rx_full_level    = four_lvl[SLOT_SPI1_RX_FULL*LEVEL_W +: LEVEL_W];
    assign o_pin_port_a_en            = four_en[SLOT_PORT_A];
    assign o_pin_port_a_level         = four_lvl[SLOT_PORT_A*LEVEL_W +: LEVEL_W];
    assign o_pin_port_b_en            = four_en[SLOT_PORT_B];
    assign o_pin_port_b_level         = four_lvl[SLOT_PORT_B*LEVEL_W +: LEVEL_W];
    assign o_pin_port_c_en            = four_en[SLOT_PORT_C];
    assign o_pin_port_c_level         = four_lvl[SLOT_PORT_C*LEVEL_W +: LEVEL_W];

    assign o_decoder1_index_en        = five_en[SLOT_DEC1_INDEX];
    assign o_decoder1_index_level     = five_lvl[SLOT_DEC1_INDEX*LEVEL_W +: LEVEL_W];
    assign o_decoder1_home_wdog_en    = five_en[SLOT_DEC1_HOME_WDOG];
    assign o_decoder1_home_wdog_level = five_lvl[SLOT_DEC1_HOME_WDOG*LEVEL_W +: LEVEL_W];
    assign o_serial1_rx_full_en       = five_en[SLOT_SER1_RX_FULL];
    assign o_serial1_rx_full_level    = five_lvl[SLOT_SER1_RX_FULL*LEVEL_W +: LEVEL_W];
    assign o_serial1_rx_error_en      = five_en[SLOT_SER1_RX_ERROR];
    assign o_serial1_rx_error_level   = five_lvl[SLOT_SER1_RX_ERROR*LEVEL_W +: LEVEL_W];
    assign o_serial1_tx_idle_en       = five_en[SLOT_SER1_TX_IDLE];
    assign o_serial1_tx_idle_level    = five_lvl[SLOT_SER1_TX_IDLE*LEVEL_W +: LEVEL_W];
    assign o_serial1_tx_empty_en      = five_en[SLOT_SER1_TX_EMPTY];
    assign o_serial1_tx_empty_level   = five_lvl[SLOT_SER1_TX_EMPTY*LEVEL_W +: LEVEL_W];
    assign o_spi_ch0_tx_empty_en      = five_en[SLOT_SPI0_TX_EMPTY];
    assign o_spi_ch0_tx_empty_level   = five_lvl[SLOT_SPI0_TX_EMPTY*LEVEL_W +: LEVEL_W];

    assign o_timer_c_ch0_en           = six_en[SLOT_TMR_C_CH0];
    assign o_timer_c_ch0_level        = six_lvl[SLOT_TMR_C_CH0*LEVEL_W +: LEVEL_W];
    assign o_timer_d_ch3_en           = six_en[SLOT_TMR_D_CH3];
    assign o_timer_d_ch3_level        = six_lvl[SLOT_TMR_D_CH3*LEVEL_W +: LEVEL_W];
    assign o_timer_d_ch2_en           = six_en[SLOT_TMR_D_CH2];
    assign o_timer_d_ch2_level        = six_lvl[SLOT_TMR_D_CH2*LEVEL_W +: LEVEL_W];
    assign o_timer_d_ch1_en           = six_en[SLOT_TMR_D_CH1];
    assign o_timer_d_ch1_level        = six_lvl[SLOT_TMR_D_CH1*LEVEL_W +: LEVEL_W];
    assign o_timer_d_ch0_en           = six_en[SLOT_TMR_D_CH0];
    assign o_timer_d_ch0_level        = six_lvl[SLOT_TMR_D_CH0*LEVEL_W +: LEVEL_W];
    assign o_decoder0_index_en        = six_en[SLOT_DEC0_INDEX];
    assign o_decoder0_index_level     = six_lvl[SLOT_DEC0_INDEX*LEVEL_W +: LEVEL_W];
    assign o_decoder0_home_wdog_en    = six_en[SLOT_DEC0_HOME_WDOG];
    assign o_decoder0_home_wdog_level = six_lvl[SLOT_DEC0_HOME_WDOG*LEVEL_W +: LEVEL_W];

endmodule
`default_nettype wire

/* File: verif/iplr_chk_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module iplr_chk
    import iplr_pkg::*;
(
    input wire logic                          i_clk,
    input wire logic                          i_rst,
    input wire logic [iplr_pkg::ADDR_W-1:0]  i_addr,
    input wire logic [iplr_pkg::DATA_W-1:0]  i_wdata,
    input wire logic                          i_wr,
    input wire logic                          i_rd,
    input wire logic [iplr_pkg::DATA_W-1:0]  o_rdata,
    input wire logic                          o_decoder1_index_en,
    input wire logic [iplr_pkg::LEVEL_W-1:0] o_decoder1_index_level,
    input wire logic                          o_spi_ch0_tx_empty_en,
    input wire logic [iplr_pkg::LEVEL_W-1:0] o_spi_ch0_tx_empty_level,
    input wire logic                          o_pin_port_c_en,
    input wire logic [iplr_pkg::LEVEL_W-1:0] o_pin_port_c_level,
    input wire logic                          o_timer_d_ch0_en,
    input wire logic [iplr_pkg::LEVEL_W-1:0] o_timer_d_ch0_level
);
    // --------
    // register port and decode
    // --------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    rd_unmapped_a: assert property (i_rd && !(i_addr inside {4'h4, 4'h5, 4'h6}) |=> o_rdata == RDATA_IDLE)
        else $error("unmapped read gave data");
    resv_four_a: assert property (i_rd && i_addr == OFS_BANK_FOUR |=> o_rdata[9:6] == 4'h0)
        else $error("bank four reserved bits set");
    resv_five_a: assert property (i_rd && i_addr == OFS_BANK_FIVE |=> o_rdata[7:6] == 2'h0)
        else $error("bank five reserved bits set");
    resv_six_a: assert property (i_rd && i_addr == OFS_BANK_SIX |=> o_rdata[5:4] == 2'h0)
        else $error("bank six reserved bits set");
    read_back_a: assert property (i_wr && i_addr == OFS_BANK_FIVE ##1 i_rd && i_addr == OFS_BANK_FIVE
        |=> o_rdata == ($past(i_wdata, 2) & MASK_FIVE)) else $error("bank five read back wrong");
    top_code_a: assert property (i_wr && i_addr == OFS_BANK_FIVE && i_wdata[15:14] == CODE_L2
        |=> ##1 o_decoder1_index_en && o_decoder1_index_level == LEVEL_2) else $error("code 3 decode");
    low_code_a: assert property (i_wr && i_addr == OFS_BANK_FIVE && i_wdata[1:0] == CODE_L0
        |=> ##1 o_spi_ch0_tx_empty_en && o_spi_ch0_tx_empty_level == LEVEL_0) else $error("code 1");
    mid_code_a: assert property (i_wr && i_addr == OFS_BANK_FOUR && i_wdata[1:0] == CODE_L1
        |=> ##1 o_pin_port_c_en && o_pin_port_c_level == LEVEL_1) else $error("code 2 decode");
    off_code_a: assert property (i_wr && i_addr == OFS_BANK_SIX && i_wdata[7:6] == CODE_OFF
        |=> ##1 !o_timer_d_ch0_en && o_timer_d_ch0_level == LEVEL_0) else $error("code 0 decode");
    reset_clear_a: assert property ($fell(i_rst) |-> !o_decoder1_index_en && !o_pin_port_c_en
        && o_rdata == RDATA_IDLE) else $error("state not cleared by reset");

    cover property (i_wr && i_addr == OFS_BANK_SIX);
    cover property (i_rd ##1 o_rdata != RDATA_IDLE);
    cover property ($fell(i_rst));
endmodule

bind iplr_top iplr_chk u_iplr_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata),
    .o_decoder1_index_en(o_decoder1_index_en), .o_decoder1_index_level(o_decoder1_index_level),
    .o_spi_ch0_tx_empty_en(o_spi_ch0_tx_empty_en),
    .o_spi_ch0_tx_empty_level(o_spi_ch0_tx_empty_level),
    .o_pin_port_c_en(o_pin_port_c_en), .o_pin_port_c_level(o_pin_port_c_level),
    .o_timer_d_ch0_en(o_timer_d_ch0_en), .o_timer_d_ch0_level(o_timer_d_ch0_level)
);
`default_nettype wire

/* File: verif/iplr_arb_model.sv */
`timescale 1ns/1ps
`default_nettype none
module iplr_arb_model
    import iplr_pkg::*;
(
    input  wire logic [23:0] i_en,
    input  wire logic [1:0]  i_lv [24],
    output logic             o_any,
    output logic [1:0]       o_top
);
    // --------
    // core side: highest level among enabled sources
    // --------
    // reserved slots never count, whatever they carry
    localparam logic [47:0] LIVE = {MASK_SIX, MASK_FIVE, MASK_FOUR};

    always_comb begin
        o_any = 1'b0;
        o_top = LEVEL_0;
        for (int k = 0; k < 24; k++) begin
            if (LIVE[2*k+:2] != 2'h0 && i_en[k] === 1'b1) begin
                o_any = 1'b1;
                if (i_lv[k] > o_top) o_top = i_lv[k];
            end
        end
    end
endmodule
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import iplr_pkg::*;
    logic              i_clk   = 1'b0;
    logic              i_rst   = 1'b1;
    logic [ADDR_W-1:0] i_addr  = 4'h0;
    logic [DATA_W-1:0] i_wdata = 16'h0000;
    logic              i_wr    = 1'b0;
    logic              i_rd    = 1'b0;
    wire  [DATA_W-1:0] o_rdata;
    wire  [23:0]       en;
    wire  [1:0]        lv [24];
    wire               arb_any;
    wire  [1:0]        arb_top;
    int                error_cnt = 0;
    int                checks    = 0;
    logic [DATA_W-1:0] rd_val;
    localparam logic [47:0] LIVE = {MASK_SIX, MASK_FIVE, MASK_FOUR};

    always #12.5 i_clk = ~i_clk;

    // --------
    // design and core model
    // --------
    iplr_top u_iplr_top (
        .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata),
        .o_spi_ch0_rx_full_en(en[7]), .o_spi_ch0_rx_full_level(lv[7]),
        .o_spi_ch1_tx_empty_en(en[6]), .o_spi_ch1_tx_empty_level(lv[6]),
        .o_spi_ch1_rx_full_en(en[5]), .o_spi_ch1_rx_full_level(lv[5]),
        .o_pin_port_a_en(en[2]), .o_pin_port_a_level(lv[2]),
        .o_pin_port_b_en(en[1]), .o_pin_port_b_level(lv[1]),
        .o_pin_port_c_en(en[0]), .o_pin_port_c_level(lv[0]),
        .o_decoder1_index_en(en[15]), .o_decoder1_index_level(lv[15]),
        .o_decoder1_home_wdog_en(en[14]), .o_decoder1_home_wdog_level(lv[14]),
        .o_serial1_rx_full_en(en[13]), .o_serial1_rx_full_level(lv[13]),
        .o_serial1_rx_error_en(en[12]), .o_serial1_rx_error_level(lv[12]),
        .o_serial1_tx_idle_en(en[10]), .o_serial1_tx_idle_level(lv[10]),
        .o_serial1_tx_empty_en(en[9]), .o_serial1_tx_empty_level(lv[9]),
        .o_spi_ch0_tx_empty_en(en[8]), .o_spi_ch0_tx_empty_level(lv[8]),
        .o_timer_c_ch0_en(en[23]), .o_timer_c_ch0_level(lv[23]),
        .o_timer_d_ch3_en(en[22]), .o_timer_d_ch3_level(lv[22]),
        .o_timer_d_ch2_en(en[21]), .o_timer_d_ch2_level(lv[21]),
        .o_timer_d_ch1_en(en[20]), .o_timer_d_ch1_level(lv[20]),
        .o_timer_d_ch0_en(en[19]), .o_timer_d_ch0_level(lv[19]),
        .o_decoder0_index_en(en[17]), .o_decoder0_index_level(lv[17]),
        .o_decoder0_home_wdog_en(en[16]), .o_decoder0_home_wdog_level(lv[16])
    );
    iplr_arb_model u_iplr_arb_model (.i_en(en), .i_lv(lv), .o_any(arb_any), .o_top(arb_top));
    // reserved slots have no source: tie them off so no net floats
    assign en[4:3] = 2'h0;
    assign en[11]  = 1'b0;
    assign en[18]  = 1'b0;
    assign lv[3]   = 2'h0;
    assign lv[4]   = 2'h0;
    assign lv[11]  = 2'h0;
    assign lv[18]  = 2'h0;

    // --------
    // bus, compare and report
    // --------
    task automatic fail(input string msg);
        error_cnt++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask
    task automatic results();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) fail($sformatf("read %h, wanted %h", got, exp));
    endtask
    task automatic chk_src(input int k, input logic [1:0] code);
        checks++;
        if (en[k] !== (code != 2'h0) || lv[k] !== ((code == 2'h0) ? 2'h0 : code - 2'h1))
            fail($sformatf("source %0d gives %b/%h for code %h", k, en[k], lv[k], code));
    endtask
    task automatic chk_arb(input logic any, input logic [1:0] top);
        checks++;
        if (arb_any !== any || arb_top !== top) fail("core view differs");
    endtask
    task automatic chk_all(input logic [15:0] p);
        for (int k = 0; k < 24; k++)
            if (LIVE[2*k+:2] != 2'h0) chk_src(k, p[2*(k%8)+:2]);
    endtask
    task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [3:0] a, output logic [15:0] d);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
        @(posedge i_clk);
    endtask
    // slot s of every bank gets code s+r, so each code meets each position
    function automatic logic [15:0] pat(input int r);
        logic [15:0] p;
        for (int s = 0; s < 8; s++)
            p[2*s+:2] = 2'(s + r);
        return p;
    endfunction

    // --------
    // scenarios
    // --------
    task automatic t_reset_state();
        for (int b = 0; b < 3; b++) begin
            bus_rd(4'(b + 4), rd_val);
            chk_reg(rd_val, BANK_RESET);
        end
        chk_all(16'h0000);
        chk_arb(1'b0, LEVEL_0);
    endtask
    task automatic t_fields();
        logic [15:0] p;
        for (int r = 0; r < 4; r++) begin
            p = pat(r);
            for (int b = 0; b < 3; b++) begin
                bus_wr(4'(b + 4), p);
                bus_rd(4'(b + 4), rd_val);
                chk_reg(rd_val, p & LIVE[16*b+:16]);
            end
            chk_all(p);
            chk_arb(1'b1, LEVEL_2);
        end
    endtask
    task automatic t_refuse();
        bus_wr(4'h7, 16'hffff);
        // let an edge pass so the strobe is not assigned twice in one step
        @(posedge i_clk);
        bus_wr(4'h3, 16'hffff);
        bus_rd(4'h7, rd_val);
        chk_reg(rd_val, RDATA_IDLE);
        for (int b = 0; b < 3; b++) begin
            bus_rd(4'(b + 4), rd_val);
            chk_reg(rd_val, pat(3) & LIVE[16*b+:16]);
        end
    endtask
    task automatic t_mid_reset();
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        t_reset_state();
    endtask

    initial begin
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        t_reset_state();
        t_fields();
        t_refuse();
        t_mid_reset();
        results();
    end
    initial begin
        #100000;
        fail("run did not finish");
        results();
    end
endmodule
`default_nettype wire
